//--- pkg/sac_pkg.sv
// constants for the successive-approximation converter control block
// assumes a 32-bit apb slave view and a pclk-rate clock enable
package sac_pkg;
  localparam int RES_W = 10;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_INSEL = 8'h08;
  localparam logic [7:0] OFF_RES_LO = 8'h0c;
  localparam logic [7:0] OFF_RES_HI = 8'h10;
  // converter_control_a fields
  localparam int CA_EN = 7;
  localparam int CA_START = 6;
  localparam int CA_ATE = 5;
  localparam int CA_DONE = 4;
  localparam int CA_IRQEN = 3;
  localparam int CA_DIV_LSB = 0;
  // converter_control_b and input_select_register fields
  localparam int CB_TSEL_LSB = 0;
  localparam int IS_REF_LSB = 6;
  localparam int IS_LEFT = 5;
  localparam int IS_CH_LSB = 0;
  // reset values
  localparam logic [2:0] DIV_RST = 3'h0;
  localparam logic [2:0] TSEL_RST = 3'h0;
  localparam logic [3:0] CH_RST = 4'h0;
  localparam logic [1:0] REF_RST = 2'h0;
  // trigger_select code that picks the conversion-done flag
  localparam logic [2:0] TSEL_FREE_RUN = 3'h0;
  // conversion timing in adc clock cycles, counted as half cycles
  localparam int NORMAL_CYC = 13;
  localparam int FIRST_CYC = 25;
  localparam int AUTO_CYC_X2 = 27;
  localparam int SH_NORMAL_X2 = 3;
  localparam int SH_FIRST_X2 = 27;
  localparam int SH_AUTO_CYC = 2;
  localparam logic [5:0] NORMAL_HALVES = 6'(2 * NORMAL_CYC);
  localparam logic [5:0] FIRST_HALVES = 6'(2 * FIRST_CYC);
  localparam logic [5:0] AUTO_HALVES = 6'(AUTO_CYC_X2);
  localparam logic [5:0] SH_NORMAL_HALVES = 6'(SH_NORMAL_X2);
  localparam logic [5:0] SH_FIRST_HALVES = 6'(SH_FIRST_X2);
  localparam logic [5:0] SH_AUTO_HALVES = 6'(2 * SH_AUTO_CYC);
  // cpu cycles spent in the trigger synchroniser and edge detector
  localparam int TRIG_SYNC_CYC = 3;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_WAIT = 2'b01,
    SAC_CONV = 2'b10
  } sac_state_t;
endpackage

//--- core/sac_conv_ctrl.sv
// conversion control for a 10-bit successive-approximation converter
// assumes an apb master on pclk and an analog core that samples on
// sample_hold and offers analog_code when a conversion completes
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/10ps
module sac_conv_ctrl #(
  parameter int NUM_TRIG = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic converter_power_reduction,
  input wire logic [NUM_TRIG-1:0] trigger_sources,
  input wire logic [sac_pkg::RES_W-1:0] analog_code,
  output logic conv_irq,
  output logic analog_power_on,
  output logic sample_hold,
  output logic [3:0] sample_channel,
  output logic [1:0] sample_reference
);
  import sac_pkg::*;

  // half of the adc clock period in pclk cycles
  function automatic logic [6:0] half_len(input logic [2:0] div);
    half_len = (div <= 3'h1) ? 7'h01 : 7'(7'h01 << (div - 3'h1));
  endfunction

  sac_state_t state, next_state;
  logic converter_enable, auto_trigger_enable, conversion_irq_enable;
  logic conversion_done_flag, left_adjust, first_pending, result_lock;
  logic [2:0] clock_divider_select, trigger_select;
  logic [3:0] channel_select;
  logic [1:0] reference_select;
  logic [6:0] presc_cnt;
  logic adc_phase;
  logic [5:0] conv_half, conv_total, conv_sh;
  logic [RES_W-1:0] result;
  logic trig_s1, trig_s2, trig_s3;
  logic [3:0] held_channel;
  logic [1:0] held_reference;

  // apb decode
  wire setup = psel & ~penable;
  wire access = psel & penable & ce;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire hit_a = paddr == OFF_CTRL_A;
  wire hit_b = paddr == OFF_CTRL_B;
  wire hit_is = paddr == OFF_INSEL;
  wire hit_lo = paddr == OFF_RES_LO;
  wire hit_hi = paddr == OFF_RES_HI;
  wire addr_ok = hit_a | hit_b | hit_is | hit_lo | hit_hi;
  wire wr_a = wr & hit_a;
  assign pready = ce;
  assign pslverr = access & ~addr_ok;

  wire en_eff = converter_enable & ~converter_power_reduction;
  wire free_mode = auto_trigger_enable & (trigger_select == TSEL_FREE_RUN);
  wire busy = state != SAC_IDLE;

  // prescaler and adc clock phase
  wire half_tick = en_eff & (presc_cnt == half_len(clock_divider_select)
                   - 7'h01);
  wire adc_rise = half_tick & ~adc_phase;

  // trigger synchroniser: s1 feeds only s2
  wire trig_sel = trigger_sources[trigger_select];
  wire trig_edge = trig_s2 & ~trig_s3 & auto_trigger_enable
                   & (trigger_select != TSEL_FREE_RUN);
  wire trig_fire = trig_edge & en_eff & ~busy;

  // conversion events
  wire in_conv = state == SAC_CONV;
  wire done_evt = in_conv & half_tick
                  & (conv_half == conv_total - 6'h01);
  wire sh_evt = in_conv & half_tick
                & (conv_half == conv_sh - 6'h01);
  wire start_wr = wr_a & pwdata[CA_START] & en_eff;
  wire restart = done_evt & free_mode;
  wire sel_locked = in_conv & (conv_half < conv_total - 6'h02);

  // a low read blocks loads only in its setup cycle, so a completion in its access cycle can still split a pair
  wire lo_setup = setup & ~pwrite & hit_lo;
  wire blocked = result_lock | lo_setup;
  wire res_load = done_evt & ~blocked;

  // result formatting
  wire [7:0] res_lo = left_adjust ? {result[1:0], 6'h00}
                                  : result[7:0];
  wire [7:0] res_hi = left_adjust ? result[9:2]
                                  : {6'h00, result[9:8]};
  wire [7:0] ctrl_a_rd = {converter_enable, busy, auto_trigger_enable,
                          conversion_done_flag, conversion_irq_enable,
                          clock_divider_select};
  wire [7:0] insel_rd = {reference_select, left_adjust, 1'b0,
                         channel_select};
  wire [7:0] rd_mux = hit_a ? ctrl_a_rd :
                      hit_b ? {5'h00, trigger_select} :
                      hit_is ? insel_rd :
                      hit_lo ? res_lo :
                      hit_hi ? res_hi : 8'h00;

  // state sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      SAC_IDLE: begin
        if (trig_fire) begin
          next_state = SAC_CONV;
        end else if (start_wr) begin
          next_state = SAC_WAIT;
        end
      end
      SAC_WAIT: begin
        if (adc_rise) begin
          next_state = SAC_CONV;
        end
      end
      SAC_CONV: begin
        if (done_evt && !restart) begin
          next_state = SAC_IDLE;
        end
      end
      default: next_state = SAC_IDLE;
    endcase
    if (!en_eff) begin
      next_state = SAC_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SAC_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // prescaler held in reset while disabled, cleared by trigger
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt <= 7'h00;
      adc_phase <= 1'b0;
    end else if (ce) begin
      if (!en_eff || trig_fire) begin
        presc_cnt <= 7'h00;
        adc_phase <= 1'b0;
      end else if (half_tick) begin
        presc_cnt <= 7'h00;
        adc_phase <= ~adc_phase;
      end else begin
        presc_cnt <= presc_cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end else if (ce) begin
      trig_s1 <= trig_sel;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end

  // conversion counter and timing kind
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_half <= 6'h00;
      conv_total <= NORMAL_HALVES;
      conv_sh <= SH_NORMAL_HALVES;
      first_pending <= 1'b1;
    end else if (ce) begin
      if (!en_eff) begin
        conv_half <= 6'h00;
        first_pending <= 1'b1;
      end else if (trig_fire || (state == SAC_WAIT && adc_rise) ||
                   restart) begin
        conv_half <= 6'h00;
        first_pending <= 1'b0;
        if (first_pending) begin
          conv_total <= FIRST_HALVES;
          conv_sh <= SH_FIRST_HALVES;
        end else if (trig_fire) begin
          conv_total <= AUTO_HALVES;
          conv_sh <= SH_AUTO_HALVES;
        end else begin
          conv_total <= NORMAL_HALVES;
          conv_sh <= SH_NORMAL_HALVES;
        end
      end else if (in_conv && half_tick) begin
        conv_half <= conv_half + 6'h01;
      end
    end
  end

  // selection buffer feeding the analog core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_channel <= CH_RST;
      held_reference <= REF_RST;
      sample_hold <= 1'b0;
    end else if (ce) begin
      sample_hold <= sh_evt;
      if (!sel_locked) begin
        held_channel <= channel_select;
        held_reference <= reference_select;
      end
    end
  end

  // selections reach the core only while enabled
  assign analog_power_on = en_eff;
  assign sample_channel = en_eff ? held_channel : 4'h0;
  assign sample_reference = en_eff ? held_reference : 2'h0;
  assign conv_irq = conversion_done_flag & conversion_irq_enable;

  // software registers, flag and result storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_enable <= 1'b0;
      auto_trigger_enable <= 1'b0;
      conversion_irq_enable <= 1'b0;
      clock_divider_select <= DIV_RST;
      trigger_select <= TSEL_RST;
      channel_select <= CH_RST;
      reference_select <= REF_RST;
      left_adjust <= 1'b0;
      conversion_done_flag <= 1'b0;
      result <= '0;
      result_lock <= 1'b0;
    end else if (ce) begin
      if (wr_a) begin
        converter_enable <= pwdata[CA_EN];
        auto_trigger_enable <= pwdata[CA_ATE];
        conversion_irq_enable <= pwdata[CA_IRQEN];
        clock_divider_select <= pwdata[CA_DIV_LSB +: 3];
      end
      if (wr & hit_b) begin
        trigger_select <= pwdata[CB_TSEL_LSB +: 3];
      end
      if (wr & hit_is) begin
        channel_select <= pwdata[IS_CH_LSB +: 4];
        reference_select <= pwdata[IS_REF_LSB +: 2];
        left_adjust <= pwdata[IS_LEFT];
      end
      // write one clears, a completion in the same cycle wins
      if (done_evt) begin
        conversion_done_flag <= 1'b1;
      end else if (wr_a && pwdata[CA_DONE]) begin
        conversion_done_flag <= 1'b0;
      end
      if (res_load) begin
        result <= analog_code;
      end
      if (rd && hit_lo) begin
        result_lock <= 1'b1;
      end else if (rd && hit_hi) begin
        result_lock <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && setup) begin
      prdata <= {24'h00_0000, rd_mux};
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_lock_holds_result: assert property (
    ce && result_lock && !(rd && hit_hi) |=> result_lock && $stable(result))
    else $error("result changed while locked");

  a_blocked_still_flags: assert property (
    ce && done_evt && blocked |=> conversion_done_flag && $stable(result))
    else $error("blocked completion lost flag or changed result");

  a_busy_through_conv: assert property (
    ce && in_conv && !done_evt && en_eff |=> ctrl_a_rd[CA_START])
    else $error("start bit dropped during conversion");

  a_channel_locked: assert property (
    ce && sel_locked && en_eff |=> $stable(held_channel)
    && $stable(held_reference))
    else $error("channel changed during conversion");

  a_trigger_starts: assert property (
    ce && trig_fire |=> in_conv && conv_half == 6'h00 && presc_cnt == 7'h00)
    else $error("trigger did not start conversion");

  a_edge_ignored: assert property (
    ce && trig_edge && in_conv && !done_evt && en_eff |=> in_conv
    && (conv_half == $past(conv_half)
    || conv_half == $past(conv_half) + 6'h01))
    else $error("edge disturbed running conversion");

  a_presc_reset: assert property (
    ce && !en_eff |=> presc_cnt == 7'h00 && !adc_phase && !busy)
    else $error("prescaler ran while disabled");

  a_wait_for_rise: assert property (
    ce && state == SAC_WAIT && en_eff |-> (adc_rise ##1 in_conv)
    or (!adc_rise ##1 state == SAC_WAIT))
    else $error("written start missed adc rise");

  a_count_bounded: assert property (
    ce && in_conv |-> conv_half < conv_total)
    else $error("conversion overran its length");

  a_free_run_keeps: assert property (
    ce && restart && en_eff |=> in_conv && conv_half == 6'h00
    && conv_total == NORMAL_HALVES)
    else $error("free running did not restart");
endmodule // sac_conv_ctrl

//--- testbench/sac_analog_model.sv
// behavioural analog core for the converter control block
// assumes sample_hold is a one-cycle pulse on pclk
`timescale 1ns/10ps
module sac_analog_model (
  input wire logic pclk,
  input wire logic power_on,
  input wire logic sample_hold,
  input wire logic [3:0] channel,
  input wire logic [1:0] reference,
  output logic [9:0] code
);
  initial code = 10'h2aa;
  always @(posedge pclk) begin
    if (!power_on) begin
      // unpowered core offers no stable code
      code <= ~code;
    end else if (sample_hold) begin
      // code names the input picked at the sampling instant
      code <= {reference, channel, 4'h5};
    end
  end
endmodule // sac_analog_model

//--- testbench/sar_adc_conversion_control_tb_top.sv
// self-checking bench for the converter control block
// assumes the analog model answers with {reference, channel, 4'h5}
`timescale 1ns/10ps
module sar_adc_conversion_control_tb_top;
  import sac_pkg::*;
  // enable plus irq enable, divider 0: the adc clock is far above the
  // full-resolution band, so results count as reduced resolution
  localparam logic [31:0] EN = 32'h88;
  logic ce = 1'b1;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, conv_irq, power_on, sh, err;
  logic pwr_red = 1'b0;
  logic [7:0] trig = 8'h00;
  logic [9:0] code;
  logic [3:0] s_ch;
  logic [1:0] s_ref;
  int err_count = 0;
  int n_checks = 0;
  int n;

  sac_conv_ctrl #(.NUM_TRIG(8)) u_dut (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .converter_power_reduction(pwr_red),
    .trigger_sources(trig), .analog_code(code), .conv_irq(conv_irq),
    .analog_power_on(power_on), .sample_hold(sh),
    .sample_channel(s_ch), .sample_reference(s_ref));
  sac_analog_model u_model (.pclk(pclk), .power_on(power_on),
    .sample_hold(sh), .channel(s_ch), .reference(s_ref), .code(code));

  always #2 pclk = ~pclk;

  task automatic final_report();
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wait_done();
    n = 0;
    while (conv_irq !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, conv_irq}, 32'h1);
  endtask
  task automatic in_range(input int lo, input int hi);
    chk({31'h0, n >= lo && n <= hi}, 32'h1);
  endtask
  task automatic chk_res(input logic [3:0] ch, input logic [1:0] rf,
                         input logic left);
    logic [9:0] c;
    c = {rf, ch, 4'h5};
    rdc(OFF_RES_LO, left ? {24'h0, c[1:0], 6'h0} : {24'h0, c[7:0]});
    rdc(OFF_RES_HI, left ? {24'h0, c[9:2]} : {22'h0, c[9:8]});
  endtask
  task automatic conv(input logic [7:0] sel);
    wr(OFF_INSEL, {24'h0, sel});
    wr(OFF_CTRL_A, EN | 32'h40);
    wait_done();
  endtask

  initial begin
    repeat (10000) @(posedge pclk);
    err_count++;
    final_report();
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFF_CTRL_A, 32'h0);
    rdc(OFF_CTRL_B, 32'h0);
    xfer(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk({31'h0, power_on}, 32'h0);
    wr(OFF_CTRL_A, EN);
    @(posedge pclk);
    chk({31'h0, power_on}, 32'h1);
    conv(8'h45);
    in_range(50, 55);
    chk_res(4'h5, 2'h1, 1'b0);
    wr(OFF_CTRL_A, EN | 32'h10);
    // busy read costs three cycles of the normal conversion
    wr(OFF_CTRL_A, EN | 32'h40);
    rdc(OFF_CTRL_A, EN | 32'h40);
    wait_done();
    in_range(22, 27);
    rdc(OFF_CTRL_A, EN | 32'h10);
    wr(OFF_CTRL_A, EN | 32'h10);
    // channel change in mid conversion
    wr(OFF_INSEL, 32'h01);
    wr(OFF_CTRL_A, EN | 32'h40);
    repeat (6) @(posedge pclk);
    wr(OFF_INSEL, 32'h02);
    chk({28'h0, s_ch}, 32'h1);
    wait_done();
    repeat (4) @(posedge pclk);
    chk({28'h0, s_ch}, 32'h2);
    chk_res(4'h1, 2'h0, 1'b0);
    wr(OFF_CTRL_A, EN | 32'h10);
    // low read locks the result pair
    conv(8'h43);
    wr(OFF_CTRL_A, EN | 32'h10);
    rdc(OFF_RES_LO, 32'h35);
    conv(8'h86);
    rdc(OFF_CTRL_A, EN | 32'h10);
    rdc(OFF_RES_HI, 32'h1);
    wr(OFF_CTRL_A, EN | 32'h10);
    conv(8'h86);
    chk_res(4'h6, 2'h2, 1'b0);
    wr(OFF_CTRL_A, EN | 32'h10);
    conv(8'hf9);
    chk_res(4'h9, 2'h3, 1'b1);
    // divider 3 gives four pclk per adc half period
    wr(OFF_CTRL_A, EN | 32'h13);
    wr(OFF_CTRL_A, EN | 32'h43);
    wait_done();
    in_range(105, 114);
    rdc(OFF_CTRL_A, EN | 32'h13);
    // flag stands with the irq masked
    wr(OFF_CTRL_A, 32'h80);
    @(posedge pclk);
    chk({31'h0, conv_irq}, 32'h0);
    rdc(OFF_CTRL_A, 32'h90);
    wr(OFF_CTRL_A, EN | 32'h10);
    // auto trigger from source 1
    wr(OFF_CTRL_B, 32'h1);
    wr(OFF_CTRL_A, EN | 32'h20);
    @(posedge pclk);
    trig <= 8'h02;
    wait_done();
    in_range(28, 34);
    wr(OFF_CTRL_A, EN | 32'h30);
    @(posedge pclk);
    trig <= 8'h00;
    @(posedge pclk);
    trig <= 8'h02;
    repeat (10) @(posedge pclk);
    trig <= 8'h00;
    @(posedge pclk);
    trig <= 8'h02;
    wait_done();
    wr(OFF_CTRL_A, EN | 32'h30);
    repeat (60) @(posedge pclk);
    chk({31'h0, conv_irq}, 32'h0);
    rdc(OFF_CTRL_A, EN | 32'h20);
    wr(OFF_CTRL_A, EN | 32'h60);
    // a low clock enable stalls the conversion and the bus
    @(posedge pclk);
    ce <= 1'b0;
    repeat (20) @(posedge pclk);
    chk({31'h0, pready}, 32'h0);
    ce <= 1'b1;
    wait_done();
    in_range(25, 30);
    // free running from the done flag
    wr(OFF_CTRL_B, 32'h0);
    wr(OFF_CTRL_A, EN | 32'h70);
    wait_done();
    wr(OFF_CTRL_A, EN | 32'h30);
    rdc(OFF_CTRL_A, EN | 32'h60);
    wait_done();
    in_range(16, 24);
    wr(OFF_CTRL_A, EN | 32'h10);
    repeat (60) @(posedge pclk);
    wr(OFF_CTRL_A, EN | 32'h10);
    rdc(OFF_CTRL_A, EN);
    wr(OFF_CTRL_A, 32'h0);
    @(posedge pclk);
    chk({31'h0, power_on}, 32'h0);
    chk({28'h0, s_ch}, 32'h0);
    pwr_red <= 1'b1;
    wr(OFF_CTRL_A, EN | 32'h40);
    chk({31'h0, power_on}, 32'h0);
    repeat (80) @(posedge pclk);
    chk({31'h0, conv_irq}, 32'h0);
    final_report();
  end
endmodule // sar_adc_conversion_control_tb_top
